// *** usrfa_regs.svh ***
// Register offsets, field positions, reset values and timing figures of the block.
`ifndef USRFA_REGS_SVH
`define USRFA_REGS_SVH
`define USRFA_OFS_CSR0          4'h0
`define USRFA_OFS_FIFOA         4'h4
`define USRFA_OFS_IRQ_STAT      4'h8
`define USRFA_OFS_IRQ_MASK      4'hC
`define USRFA_CSR0_RESUME       10
`define USRFA_CSR0_SUSP         9
`define USRFA_CSR0_PERMIT       8
`define USRFA_CSR0_ADDR_HI      6
`define USRFA_FIFO_RX_HI        28
`define USRFA_FIFO_RX_LO        16
`define USRFA_FIFO_TX_HI        12
`define USRFA_FIFO_TX_LO        0
`define USRFA_CSR0_RST          32'h0000_0000
`define USRFA_FIFOA_RST         32'h0000_0000
`define USRFA_IRQ_RST           4'h0
`define USRFA_CLK_PERIOD_NS     10
`define USRFA_RESUME_DEV_MAX_NS 15000000
`define USRFA_RESUME_HOST_NS    20000000
`endif

// *** usrfa_pkg.sv ***
// Types shared by the suspend, resume and FIFO base block.
package usrfa_pkg;
    typedef enum logic [2:0] {
        USRFA_NORMAL    = 3'h1,
        USRFA_SUSPENDED = 3'h2,
        USRFA_RESUMING  = 3'h4
    } usrfa_state_t;

    typedef struct packed {
        logic        wr;
        logic        hit;
        logic [3:0]  ofs;
        logic [31:0] dat;
        logic [3:0]  sel;
    } usrfa_wb_acc_t;

    typedef struct packed {
        logic overrun;
        logic addr_hit;
        logic susp_out;
        logic susp_in;
    } usrfa_evt_t;
endpackage

// *** usrfa_wb_slave.sv ***
// Classic Wishbone slave front end: acknowledge, decode and read data register.
`timescale 1ns/1ps
module usrfa_wb_slave #(
    parameter int AW = 6
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [AW-1:0]          wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    input  wire logic [31:0]            rdata_i,
    output logic                        wb_ack_o,
    output logic [31:0]                 wb_dat_o,
    output usrfa_pkg::usrfa_wb_acc_t    acc_o
);
    logic req;
    logic hit;

    assign req = wb_cyc_i && wb_stb_i;
    assign hit = (wb_adr_i[AW-1:4] == '0);

    // Writes land on the edge where the master sees ack, never earlier.
    always_comb begin
        acc_o.wr  = req && wb_we_i && wb_ack_o && hit;
        acc_o.hit = hit;
        acc_o.ofs = {wb_adr_i[3:2], 2'b00};
        acc_o.dat = wb_dat_i;
        acc_o.sel = wb_sel_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    // Unmapped addresses still answer, reading as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_ack_o) begin
            wb_dat_o <= (hit && !wb_we_i) ? rdata_i : 32'h0000_0000;
        end
    end
endmodule

// *** usrfa_addr_match.sv ***
// Function address comparator for incoming token packets.
`timescale 1ns/1ps
module usrfa_addr_match (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic [6:0] dev_addr_i,
    input  wire logic       token_valid_i,
    input  wire logic [6:0] token_addr_i,
    output logic            match_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_o <= 1'b0;
        end else begin
            match_o <= enable_i && token_valid_i && (token_addr_i == dev_addr_i);
        end
    end

    property p_addr_match;
        token_valid_i && enable_i && (token_addr_i == dev_addr_i) |=> match_o;
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("token with own address was not matched");

    property p_no_match_host;
        !enable_i |=> !match_o;
    endproperty
    a_no_match_host: assert property (p_no_match_host)
        else $error("address match flagged while matching is disabled");
endmodule

// *** usrfa_top.sv ***
// Suspend, resume, function address and endpoint FIFO base control block.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "usrfa_regs.svh"
module usrfa_top #(
    parameter int          AW              = 6,
    parameter int unsigned RESUME_DEV_CYC  = `USRFA_RESUME_DEV_MAX_NS / `USRFA_CLK_PERIOD_NS,
    parameter int unsigned RESUME_HOST_CYC = `USRFA_RESUME_HOST_NS / `USRFA_CLK_PERIOD_NS
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [AW-1:0] wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic               wb_ack_o,
    output logic [31:0]        wb_dat_o,
    input  wire logic          role_host_i,
    input  wire logic          link_suspend_i,
    input  wire logic          link_resume_i,
    input  wire logic          token_valid_i,
    input  wire logic [6:0]    token_addr_i,
    output logic               resume_drive_o,
    output logic               suspended_o,
    output logic               addr_match_o,
    output logic [15:0]        rx_fifo_base_o,
    output logic [15:0]        tx_fifo_base_o,
    output logic               irq_o
);
    localparam int FW = `USRFA_FIFO_RX_HI - `USRFA_FIFO_RX_LO + 1;
    // Reset words held as sized constants so that single fields can be selected from them.
    localparam logic [31:0] CSR0_RST  = `USRFA_CSR0_RST;
    localparam logic [31:0] FIFOA_RST = `USRFA_FIFOA_RST;

    usrfa_pkg::usrfa_wb_acc_t acc;
    usrfa_pkg::usrfa_state_t  state;
    usrfa_pkg::usrfa_state_t  next_state;
    usrfa_pkg::usrfa_evt_t    evt;

    logic [31:0] rdata;
    logic        resume_ctl;
    logic        suspend_permit;
    logic [6:0]  device_bus_address;
    logic [FW-1:0] rx_endpoint_buffer_start;
    logic [FW-1:0] tx_endpoint_buffer_start;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [31:0] res_cnt;
    logic [31:0] res_lim;
    logic        suspend_state_flag;
    logic        host_susp_req;
    logic        wr_csr0;
    logic        wr_fifoa;
    logic        wr_stat;
    logic        wr_mask;
    logic [31:0] csr0_word;
    logic [31:0] fifoa_word;
    logic [31:0] fifoa_merged;
    logic [31:0] mask_merged;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    usrfa_wb_slave #(
        .AW (AW)
    ) u_wb (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .rdata_i  (rdata),
        .wb_ack_o (wb_ack_o),
        .wb_dat_o (wb_dat_o),
        .acc_o    (acc)
    );

    assign wr_csr0  = acc.wr && (acc.ofs == `USRFA_OFS_CSR0);
    assign wr_fifoa = acc.wr && (acc.ofs == `USRFA_OFS_FIFOA);
    assign wr_stat  = acc.wr && (acc.ofs == `USRFA_OFS_IRQ_STAT);
    assign wr_mask  = acc.wr && (acc.ofs == `USRFA_OFS_IRQ_MASK);

    assign csr0_word = {21'h00_0000, resume_ctl, suspend_state_flag, suspend_permit,
                        1'b0, role_host_i ? 7'h00 : device_bus_address};
    assign fifoa_word = {3'h0, rx_endpoint_buffer_start, 3'h0, tx_endpoint_buffer_start};

    // A partial write keeps the byte lanes that sel leaves out.
    // The merged words are formed once, so both registers apply the lanes the same way.
    assign fifoa_merged = merge(fifoa_word, acc.dat, acc.sel);
    assign mask_merged  = merge({28'h000_0000, irq_mask}, acc.dat, acc.sel);

    always_comb begin
        unique case (acc.ofs)
            `USRFA_OFS_CSR0:     rdata = csr0_word;
            `USRFA_OFS_FIFOA:    rdata = fifoa_word;
            `USRFA_OFS_IRQ_STAT: rdata = {28'h000_0000, irq_stat};
            `USRFA_OFS_IRQ_MASK: rdata = {28'h000_0000, irq_mask};
            default:             rdata = 32'h0000_0000;
        endcase
    end

    // Control bits of the control and status word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resume_ctl         <= CSR0_RST[`USRFA_CSR0_RESUME];
            suspend_permit     <= CSR0_RST[`USRFA_CSR0_PERMIT];
            device_bus_address <= 7'h00;
        end else if (wr_csr0) begin
            if (acc.sel[1]) begin
                resume_ctl     <= acc.dat[`USRFA_CSR0_RESUME];
                suspend_permit <= acc.dat[`USRFA_CSR0_PERMIT];
            end
            if (acc.sel[0] && !role_host_i) begin
                device_bus_address <= acc.dat[`USRFA_CSR0_ADDR_HI:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_endpoint_buffer_start <= FIFOA_RST[`USRFA_FIFO_RX_HI:`USRFA_FIFO_RX_LO];
            tx_endpoint_buffer_start <= FIFOA_RST[`USRFA_FIFO_TX_HI:`USRFA_FIFO_TX_LO];
        end else if (wr_fifoa) begin
            rx_endpoint_buffer_start <= fifoa_merged[`USRFA_FIFO_RX_HI:`USRFA_FIFO_RX_LO];
            tx_endpoint_buffer_start <= fifoa_merged[`USRFA_FIFO_TX_HI:`USRFA_FIFO_TX_LO];
        end
    end

    // The bases are byte addresses, so the all-ones code lands on the last 8-byte unit.
    assign rx_fifo_base_o = {rx_endpoint_buffer_start, 3'h0};
    assign tx_fifo_base_o = {tx_endpoint_buffer_start, 3'h0};

    assign host_susp_req = wr_csr0 && role_host_i && acc.sel[1]
                           && acc.dat[`USRFA_CSR0_SUSP];

    always_comb begin
        next_state = state;
        unique case (state)
            usrfa_pkg::USRFA_NORMAL: begin
                if (suspend_permit && (role_host_i ? host_susp_req : link_suspend_i)) begin
                    next_state = usrfa_pkg::USRFA_SUSPENDED;
                end
            end
            usrfa_pkg::USRFA_SUSPENDED: begin
                if (resume_ctl) begin
                    next_state = usrfa_pkg::USRFA_RESUMING;
                end else if (link_resume_i) begin
                    next_state = usrfa_pkg::USRFA_NORMAL;
                end
            end
            usrfa_pkg::USRFA_RESUMING: begin
                if (!resume_ctl) begin
                    next_state = usrfa_pkg::USRFA_NORMAL;
                end
            end
            default: next_state = usrfa_pkg::USRFA_NORMAL;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= usrfa_pkg::USRFA_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    assign suspend_state_flag = (state != usrfa_pkg::USRFA_NORMAL);
    assign suspended_o        = suspend_state_flag;
    assign resume_drive_o     = (state == usrfa_pkg::USRFA_RESUMING);

    assign res_lim = role_host_i ? 32'(RESUME_HOST_CYC) : 32'(RESUME_DEV_CYC);

    // Software may forget to clear resume; the counter only reports it and
    // keeps driving, because cutting resume short would break the link timing.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_cnt <= 32'h0000_0000;
        end else if (!resume_drive_o) begin
            res_cnt <= 32'h0000_0000;
        end else if (res_cnt != res_lim) begin
            res_cnt <= res_cnt + 32'h0000_0001;
        end
    end

    usrfa_addr_match u_match (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .enable_i      (!role_host_i),
        .dev_addr_i    (device_bus_address),
        .token_valid_i (token_valid_i),
        .token_addr_i  (token_addr_i),
        .match_o       (addr_match_o)
    );

    always_comb begin
        evt.susp_in  = (state == usrfa_pkg::USRFA_NORMAL)
                       && (next_state == usrfa_pkg::USRFA_SUSPENDED);
        evt.susp_out = suspend_state_flag && (next_state == usrfa_pkg::USRFA_NORMAL);
        evt.addr_hit = addr_match_o;
        evt.overrun  = resume_drive_o && (res_cnt == res_lim - 32'h0000_0001);
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= `USRFA_IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & ~(wr_stat ? acc.dat[3:0] & {4{acc.sel[0]}} : 4'h0))
                        | evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= `USRFA_IRQ_RST;
        end else if (wr_mask) begin
            irq_mask <= mask_merged[3:0];
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic rd_csr0_ack;
    logic rd_fifo_ack;
    assign rd_csr0_ack = wb_ack_o && !wb_we_i && acc.hit && (acc.ofs == `USRFA_OFS_CSR0);
    assign rd_fifo_ack = wb_ack_o && !wb_we_i && acc.hit && (acc.ofs == `USRFA_OFS_FIFOA);

    property p_resume_start;
        (state == usrfa_pkg::USRFA_SUSPENDED) && resume_ctl |=> resume_drive_o;
    endproperty
    a_resume_start: assert property (p_resume_start)
        else $error("resume not driven while suspended with resume set");

    property p_resume_stop;
        !resume_ctl |=> !resume_drive_o;
    endproperty
    a_resume_stop: assert property (p_resume_stop)
        else $error("resume still driven after the control bit cleared");

    property p_resume_only_susp;
        $rose(resume_drive_o) |-> $past(suspend_state_flag);
    endproperty
    a_resume_only_susp: assert property (p_resume_only_susp)
        else $error("resume started while not suspended");

    property p_flag_read;
        rd_csr0_ack |-> wb_dat_o[`USRFA_CSR0_SUSP] == $past(suspended_o);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("suspend flag read back differs from state");

    property p_dev_entry;
        $rose(suspended_o) && !$past(role_host_i) |-> $past(link_suspend_i);
    endproperty
    a_dev_entry: assert property (p_dev_entry)
        else $error("device role entered suspend without link cause");

    property p_hold_susp;
        (state == usrfa_pkg::USRFA_SUSPENDED) && !resume_ctl && !link_resume_i
        |=> suspended_o;
    endproperty
    a_hold_susp: assert property (p_hold_susp)
        else $error("suspend flag cleared without a leaving cause");

    property p_permit;
        $rose(suspended_o) |-> $past(suspend_permit);
    endproperty
    a_permit: assert property (p_permit)
        else $error("suspend entered while not permitted");

    property p_rx_base;
        wr_fifoa && (acc.sel == 4'hF)
        |=> rx_fifo_base_o == {$past(wb_dat_i[28:16]), 3'h0};
    endproperty
    a_rx_base: assert property (p_rx_base)
        else $error("receive base differs from written field");

    property p_tx_base;
        wr_fifoa && (acc.sel == 4'hF)
        |=> tx_fifo_base_o == {$past(wb_dat_i[12:0]), 3'h0};
    endproperty
    a_tx_base: assert property (p_tx_base)
        else $error("transmit base differs from written field");

    property p_fifo_zero;
        rd_fifo_ack |-> (wb_dat_o[31:29] == 3'h0) && (wb_dat_o[15:13] == 3'h0);
    endproperty
    a_fifo_zero: assert property (p_fifo_zero)
        else $error("unimplemented FIFO register bits read nonzero");

    property p_sticky;
        evt.addr_hit |=> irq_stat[2];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("address event lost from status");

    // A clear without a new event must really drop the bit.
    property p_stat_clear;
        wr_stat && acc.sel[0] && acc.dat[2] && !evt.addr_hit |=> !irq_stat[2];
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("status bit survived a write-one clear");

    c_enter: cover property ($rose(suspended_o));
    c_resume: cover property ($rose(resume_drive_o) ##[1:50] !resume_drive_o);
    c_match: cover property (addr_match_o);
    c_irq: cover property ($rose(irq_o));
    c_overrun: cover property (evt.overrun);
endmodule

// *** usrfa_bus_partner.sv ***
// Behavioural model of the USB bus party facing the block.
`timescale 1ns/1ps
module usrfa_bus_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       resume_drive_i,
    output logic            link_suspend_o,
    output logic            link_resume_o,
    output logic            token_valid_o,
    output logic [6:0]      token_addr_o
);
    int resume_len;

    initial begin
        link_suspend_o = 1'b0;
        link_resume_o  = 1'b0;
        token_valid_o  = 1'b0;
        token_addr_o   = 7'h00;
    end

    // Length of the resume signalling seen on the bus, for the software side to judge.
    always @(posedge clk_i) begin
        if (rst_i || !resume_drive_i) begin
            resume_len <= 0;
        end else begin
            resume_len <= resume_len + 1;
        end
    end

    task automatic pulse_suspend();
        @(posedge clk_i);
        link_suspend_o <= 1'b1;
        @(posedge clk_i);
        link_suspend_o <= 1'b0;
    endtask

    task automatic pulse_resume();
        @(posedge clk_i);
        link_resume_o <= 1'b1;
        @(posedge clk_i);
        link_resume_o <= 1'b0;
    endtask

    // token address field
    // The address lines show the inverse once released, so a stale value never matches.
    task automatic send_token(input logic [6:0] a);
        @(posedge clk_i);
        token_valid_o <= 1'b1;
        token_addr_o  <= a;
        @(posedge clk_i);
        token_valid_o <= 1'b0;
        token_addr_o  <= ~a;
    endtask
endmodule

// *** tb_usb_suspend_resume_fifo_addr.sv ***
// Self-checking testbench of the suspend, resume, address and FIFO base block.
`timescale 1ns/1ps
module tb_usb_suspend_resume_fifo_addr;
    localparam int DEV_CYC  = 20;
    localparam int HOST_CYC = 30;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack, role = 1'b0, lsusp, lres, tval, rdrv, susp, match, irq;
    logic [6:0]  taddr;
    logic [15:0] rxb, txb;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc_cnt = 0;

    always #5 clk_i = ~clk_i;

    usrfa_top #(.AW(6), .RESUME_DEV_CYC(DEV_CYC), .RESUME_HOST_CYC(HOST_CYC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .role_host_i(role), .link_suspend_i(lsusp), .link_resume_i(lres),
        .token_valid_i(tval), .token_addr_i(taddr), .resume_drive_o(rdrv),
        .suspended_o(susp), .addr_match_o(match), .rx_fifo_base_o(rxb),
        .tx_fifo_base_o(txb), .irq_o(irq));

    usrfa_bus_partner i_partner (
        .clk_i(clk_i), .rst_i(rst_i), .resume_drive_i(rdrv), .link_suspend_o(lsusp),
        .link_resume_o(lres), .token_valid_o(tval), .token_addr_o(taddr));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic single cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 50) chk("ack", 32'h1, 32'h0);
    endtask

    task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    task automatic wr_wait(input logic [5:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        @(posedge clk_i);
        #1;
    endtask

    task automatic do_reset(input logic host);
        @(posedge clk_i);
        rst_i <= 1'b1;
        role  <= host;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic t_regs();
        rd_chk("csr0", 6'h00, 32'h0);
        rd_chk("fifoa", 6'h04, 32'h0);
        rd_chk("stat", 6'h08, 32'h0);
        rd_chk("mask", 6'h0C, 32'h0);
        wb(1'b1, 6'h10, 32'hFFFFFFFF);
        rd_chk("unmapped", 6'h10, 32'h0);
        wr_wait(6'h04, 32'hFFFFFFFF);
        rd_chk("fifoa", 6'h04, 32'h1FFF1FFF);
        chk("rx_base", 32'h0000FFF8, {16'h0, rxb});
        chk("tx_base", 32'h0000FFF8, {16'h0, txb});
        wr_wait(6'h04, 32'h00050003);
        chk("rx_base", 32'h00000028, {16'h0, rxb});
        chk("tx_base", 32'h00000018, {16'h0, txb});
        $display("test regs done");
    endtask

    task automatic t_addr();
        wr_wait(6'h00, 32'h000000AA);
        rd_chk("device_bus_address_addr", 6'h00, 32'h0000002A);
        i_partner.send_token(7'h2B);
        #1;
        chk("match_miss", 32'h0, {31'h0, match});
        i_partner.send_token(7'h2A);
        #1;
        chk("match_hit", 32'h1, {31'h0, match});
        rd_chk("stat", 6'h08, 32'h00000004);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr_wait(6'h0C, 32'h00000004);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr_wait(6'h08, 32'h00000004);
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr_wait(6'h0C, 32'h00000000);
        $display("test addr done");
    endtask

    task automatic t_dev_suspend();
        wr_wait(6'h00, 32'h00000400);
        chk("resume_idle", 32'h0, {31'h0, rdrv});
        wr_wait(6'h00, 32'h00000000);
        i_partner.pulse_suspend();
        #1;
        chk("susp_noperm", 32'h0, {31'h0, susp});
        wr_wait(6'h00, 32'h00000100);
        i_partner.pulse_suspend();
        #1;
        chk("susp_dev", 32'h1, {31'h0, susp});
        wr_wait(6'h00, 32'h00000100);
        rd_chk("csr0_susp", 6'h00, 32'h00000300);
        wr_wait(6'h00, 32'h00000500);
        chk("resume_drv", 32'h1, {31'h0, rdrv});
        // Software ends resume after DEV_CYC * 2 / 3 = 13 cycles, inside the 20-cycle DEV_CYC ceiling.
        repeat (DEV_CYC * 2 / 3) @(posedge clk_i);
        #1;
        chk("resume_len", DEV_CYC * 2 / 3, i_partner.resume_len);
        wr_wait(6'h00, 32'h00000100);
        chk("resume_stop", 32'h0, {31'h0, rdrv});
        chk("susp_left", 32'h0, {31'h0, susp});
        rd_chk("stat", 6'h08, 32'h00000003);
        $display("test dev_suspend done");
    endtask

    task automatic t_host_suspend();
        wr_wait(6'h00, 32'h00000200);
        chk("host_noperm", 32'h0, {31'h0, susp});
        // Entry needs the permit bit already set before the suspend request.
        wr_wait(6'h00, 32'h00000100);
        wr_wait(6'h00, 32'h0000037F);
        chk("host_susp", 32'h1, {31'h0, susp});
        rd_chk("host_csr0", 6'h00, 32'h00000300);
        i_partner.pulse_resume();
        #1;
        chk("host_hw_clr", 32'h0, {31'h0, susp});
        wr_wait(6'h00, 32'h00000300);
        wr_wait(6'h00, 32'h00000700);
        chk("host_resume", 32'h1, {31'h0, rdrv});
        repeat (HOST_CYC) @(posedge clk_i);
        #1;
        chk("host_res_len", HOST_CYC, i_partner.resume_len);
        wr_wait(6'h00, 32'h00000100);
        chk("host_stop", 32'h0, {31'h0, rdrv});
        // Entries, exits and the resume held to the limit all leave their status bits.
        rd_chk("host_stat", 6'h08, 32'h0000000B);
        $display("test host_suspend done");
    endtask

    initial begin
        do_reset(1'b0);
        t_regs();
        t_addr();
        t_dev_suspend();
        do_reset(1'b1);
        t_host_suspend();
        end_of_test();
    end
endmodule
